/* File: shared/tc_limit_pkg.sv */
package tc_limit_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (low address reads, offset with bit 7 set writes)
  localparam logic [6:0] OFFS_CJ_HIGH_LIMIT = 7'h03;
  localparam logic [6:0] OFFS_CJ_LOW_LIMIT = 7'h04;
  localparam logic [6:0] OFFS_TC_HIGH_UPPER = 7'h05;
  localparam logic [6:0] OFFS_TC_HIGH_LOWER = 7'h06;
  localparam logic [6:0] OFFS_TC_LOW_UPPER = 7'h07;
  localparam logic [6:0] OFFS_TC_LOW_LOWER = 7'h08;
  localparam logic [6:0] OFFS_CJ_OFFSET = 7'h09;
  localparam logic [6:0] OFFS_CJ_TEMP_UPPER = 7'h0a;
  localparam logic [6:0] OFFS_CJ_TEMP_LOWER = 7'h0b;
  localparam logic [6:0] OFFS_TC_BYTE_TWO = 7'h0c;
  localparam logic [6:0] OFFS_TC_BYTE_ONE = 7'h0d;
  localparam logic [6:0] OFFS_TC_BYTE_ZERO = 7'h0e;
  localparam logic [6:0] OFFS_FAULT_FLAGS = 7'h0f;
  localparam int WRITE_FLAG_BIT = 7;

  //////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] RST_CJ_HIGH_LIMIT = 8'h7f;
  localparam logic [7:0] RST_CJ_LOW_LIMIT = 8'hc0;
  localparam logic [7:0] RST_TC_HIGH_UPPER = 8'h7f;
  localparam logic [7:0] RST_TC_HIGH_LOWER = 8'hff;
  localparam logic [7:0] RST_TC_LOW_UPPER = 8'h80;
  localparam logic [7:0] RST_TC_LOW_LOWER = 8'h00;
  localparam logic [7:0] RST_CJ_OFFSET = 8'h00;
  localparam logic [13:0] RST_CJ_TEMP = 14'h0000;
  localparam logic [18:0] RST_TC_RESULT = 19'h00000;
  localparam logic [7:0] RST_FAULT_FLAGS = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // value formats
  localparam int CJ_WIDTH = 14;
  localparam int TC_WIDTH = 19;
  localparam int CJ_LIMIT_WIDTH = 8;
  localparam int TC_LIMIT_WIDTH = 16;
  // cj temperature lsb is 2^-6, cj limit lsb 2^0
  localparam int CJ_LIMIT_SHIFT = 6;
  // tc result lsb is 2^-7, tc limit lsb 2^-4
  localparam int TC_LIMIT_SHIFT = 3;
  // cj offset lsb is 2^-4
  localparam int CJ_OFFSET_SHIFT = 2;
  // +128 degC is one lsb beyond 14-bit range, so top clamp is the largest code
  localparam logic [13:0] CJ_CLAMP_MAX = 14'h1fff;
  // -64 degC in 2^-6 units
  localparam logic [13:0] CJ_CLAMP_MIN = 14'h3000;

  //////////////////////////////////////////////////////////////////////////////
  // fault flag bit positions
  localparam int FLAG_COLD_JUNCTION_OUT_OF_RANGE = 7;
  localparam int FLAG_THERMOCOUPLE_OUT_OF_RANGE = 6;
  localparam int FLAG_CJ_HIGH = 5;
  localparam int FLAG_CJ_LOW = 4;
  localparam int FLAG_TC_HIGH = 3;
  localparam int FLAG_TC_LOW = 2;
  localparam int FLAG_VOLTAGE = 1;
  localparam int FLAG_OPEN = 0;
  localparam int FLAG_COUNT = 8;
  localparam int MASKABLE_COUNT = 6;

endpackage : tc_limit_pkg

/* File: hdl/limit_compare.sv */
`timescale 1ns/1ps

module limit_compare #(
  parameter int VALUE_W = 14,
  parameter int LIMIT_W = 8,
  parameter int SHIFT = 6
) (
  input wire logic [VALUE_W-1:0] value_i,
  input wire logic [LIMIT_W-1:0] high_limit_i,
  input wire logic [LIMIT_W-1:0] low_limit_i,
  output logic over_o,
  output logic under_o
);

  // limits are scaled onto the value's lsb weight; VALUE_W = LIMIT_W + SHIFT
  wire logic signed [VALUE_W-1:0] high_scaled;
  wire logic signed [VALUE_W-1:0] low_scaled;

  assign high_scaled = $signed({high_limit_i, {SHIFT{1'b0}}});
  assign low_scaled = $signed({low_limit_i, {SHIFT{1'b0}}});

  // strict compare: a value equal to the limit is not a fault
  assign over_o = $signed(value_i) > high_scaled;
  assign under_o = $signed(value_i) < low_scaled;

endmodule : limit_compare

/* File: hdl/fault_latch.sv */
`timescale 1ns/1ps

module fault_latch (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic interrupt_mode_i,
  input wire logic clear_i,
  input wire logic [tc_limit_pkg::FLAG_COUNT-1:0] cond_i,
  output logic [tc_limit_pkg::FLAG_COUNT-1:0] flags_o
);

  logic [tc_limit_pkg::FLAG_COUNT-1:0] flags_q;
  logic [tc_limit_pkg::FLAG_COUNT-1:0] flags_d;

  genvar i;
  generate
    for (i = 0; i < tc_limit_pkg::FLAG_COUNT; i++)
    begin : g_flag
      // a live condition wins over a clear in the same cycle
      assign flags_d[i] = interrupt_mode_i ? (cond_i[i] | (flags_q[i] & ~clear_i)) : cond_i[i];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      flags_q <= tc_limit_pkg::RST_FAULT_FLAGS;
    else
      flags_q <= flags_d;
  end

  assign flags_o = flags_q;

endmodule : fault_latch

/* File: hdl/tc_fault_limit_regs.sv */
`timescale 1ns/1ps

// Function
// - flag cold-junction high when cj temperature exceeds signed 8-bit high limit.
// - flag cold-junction low when cj temperature is below signed 8-bit low limit.
// - flag thermocouple high when result exceeds 16-bit signed high limit.
// - flag thermocouple low when result is below 16-bit signed low limit.
// - comparisons always set flags; unmasked ones also pull fault output low.
// - with internal sensor enabled, add signed offset to measured cj temperature.
// - with internal sensor enabled, cj temperature bytes are read-only measured plus offset.
// - with internal sensor enabled, reading a cj temperature byte releases result ready high.
// - with sensor off, cj bytes keep last result and accept host writes.
// - cj temperature is clamped between minus 64 and plus 128 degrees.
// - cj temperature is 14-bit signed; lower byte's two lowest bits read zero.
// - present 19-bit signed linearized result over three read-only bytes.
// - fault flag byte order: cold-junction out-of-range down to open circuit.
// - comparator mode: flags follow their fault conditions directly.
// - interrupt mode: flags latch until host writes the fault-clear bit.
// - after a clear, flags set again as soon as a fault is seen.
// - out-of-range flags never drive the fault output.
// - masked faults still set their flag; mask only affects fault output.
module tc_fault_limit_regs (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic INTERRUPT_MODE_I,
  input wire logic FAULT_CLEAR_I,
  input wire logic CJ_SENSOR_DISABLE_I,
  input wire logic [5:0] FAULT_MASK_I,
  input wire logic [13:0] CJ_MEASURED_I,
  input wire logic CJ_VALID_I,
  input wire logic [18:0] TC_RESULT_I,
  input wire logic TC_VALID_I,
  input wire logic COLD_JUNCTION_OUT_OF_RANGE_I,
  input wire logic THERMOCOUPLE_OUT_OF_RANGE_I,
  input wire logic INPUT_VOLTAGE_FAULT_I,
  input wire logic OPEN_CIRCUIT_I,
  output logic [13:0] CJ_TEMP_O,
  output logic FAULT_N_O,
  output logic RESULT_READY_N_O
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  function automatic logic read_hit(input logic [7:0] addr, input logic [6:0] offs);
    read_hit = (addr[tc_limit_pkg::WRITE_FLAG_BIT] == 1'b0) && (addr[6:0] == offs);
  endfunction : read_hit

  function automatic logic write_hit(input logic [7:0] addr, input logic [6:0] offs);
    write_hit = (addr[tc_limit_pkg::WRITE_FLAG_BIT] == 1'b1) && (addr[6:0] == offs);
  endfunction : write_hit

  function automatic logic [13:0] clamp_cj(input logic [14:0] v);
    logic signed [14:0] s;
    s = $signed(v);
    if (s > $signed({tc_limit_pkg::CJ_CLAMP_MAX[13], tc_limit_pkg::CJ_CLAMP_MAX}))
      clamp_cj = tc_limit_pkg::CJ_CLAMP_MAX;
    else if (s < $signed({tc_limit_pkg::CJ_CLAMP_MIN[13], tc_limit_pkg::CJ_CLAMP_MIN}))
      clamp_cj = tc_limit_pkg::CJ_CLAMP_MIN;
    else
      clamp_cj = v[13:0];
  endfunction : clamp_cj

  //////////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] cj_high_limit_q;
  logic [7:0] cj_low_limit_q;
  logic [7:0] tc_high_upper_q;
  logic [7:0] tc_high_lower_q;
  logic [7:0] tc_low_upper_q;
  logic [7:0] tc_low_lower_q;
  logic [7:0] cj_offset_q;
  logic [13:0] cj_temp_q;
  logic [13:0] cj_temp_d;
  logic [18:0] tc_result_q;
  logic [18:0] tc_result_d;
  logic ready_n_q;
  logic ready_n_d;
  logic fault_n_q;
  logic fault_n_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  //////////////////////////////////////////////////////////////////////////////
  // limit registers; writes only through the bit-7 alias

  wire logic wr_cj_high = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_HIGH_LIMIT);
  wire logic wr_cj_low = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_LOW_LIMIT);
  wire logic wr_tc_hi_up = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_TC_HIGH_UPPER);
  wire logic wr_tc_hi_lo = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_TC_HIGH_LOWER);
  wire logic wr_tc_lo_up = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_TC_LOW_UPPER);
  wire logic wr_tc_lo_lo = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_TC_LOW_LOWER);
  wire logic wr_cj_offset = REG_WR_I & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_OFFSET);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      cj_high_limit_q <= tc_limit_pkg::RST_CJ_HIGH_LIMIT;
      cj_low_limit_q <= tc_limit_pkg::RST_CJ_LOW_LIMIT;
      tc_high_upper_q <= tc_limit_pkg::RST_TC_HIGH_UPPER;
      tc_high_lower_q <= tc_limit_pkg::RST_TC_HIGH_LOWER;
      tc_low_upper_q <= tc_limit_pkg::RST_TC_LOW_UPPER;
      tc_low_lower_q <= tc_limit_pkg::RST_TC_LOW_LOWER;
      cj_offset_q <= tc_limit_pkg::RST_CJ_OFFSET;
    end
    else
    begin
      if (wr_cj_high)
        cj_high_limit_q <= REG_WDATA_I;
      if (wr_cj_low)
        cj_low_limit_q <= REG_WDATA_I;
      if (wr_tc_hi_up)
        tc_high_upper_q <= REG_WDATA_I;
      if (wr_tc_hi_lo)
        tc_high_lower_q <= REG_WDATA_I;
      if (wr_tc_lo_up)
        tc_low_upper_q <= REG_WDATA_I;
      if (wr_tc_lo_lo)
        tc_low_lower_q <= REG_WDATA_I;
      if (wr_cj_offset)
        cj_offset_q <= REG_WDATA_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cold-junction temperature

  wire logic cj_sensor_en = ~CJ_SENSOR_DISABLE_I;

  wire logic [14:0] cj_offset_ext = {{5{cj_offset_q[7]}}, cj_offset_q, {tc_limit_pkg::CJ_OFFSET_SHIFT{1'b0}}};
  wire logic [14:0] cj_sum = 15'({CJ_MEASURED_I[13], CJ_MEASURED_I} + cj_offset_ext);

  // host writes only while the internal sensor is off
  wire logic wr_cj_upper = REG_WR_I & CJ_SENSOR_DISABLE_I
                           & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_TEMP_UPPER);
  wire logic wr_cj_lower = REG_WR_I & CJ_SENSOR_DISABLE_I
                           & write_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_TEMP_LOWER);
  // low two bits of the lower byte are dropped when written
  wire logic [13:0] cj_upper_written = {REG_WDATA_I, cj_temp_q[5:0]};
  wire logic [13:0] cj_lower_written = {cj_temp_q[13:6], REG_WDATA_I[7:2]};

  // conversions only land while the sensor is enabled
  // every load path goes through the clamp
  assign cj_temp_d = (cj_sensor_en & CJ_VALID_I) ? clamp_cj(cj_sum) :
                     wr_cj_upper ? clamp_cj({cj_upper_written[13], cj_upper_written}) :
                     wr_cj_lower ? clamp_cj({cj_lower_written[13], cj_lower_written}) :
                     cj_temp_q;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      cj_temp_q <= tc_limit_pkg::RST_CJ_TEMP;
    else
      cj_temp_q <= cj_temp_d;
  end

  assign CJ_TEMP_O = cj_temp_q;

  //////////////////////////////////////////////////////////////////////////////
  // linearized result and result-ready

  // result captured whole so the three bytes stay coherent
  assign tc_result_d = TC_VALID_I ? TC_RESULT_I : tc_result_q;

  wire logic rd_cj_byte = REG_RD_I & (read_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_TEMP_UPPER)
                                      | read_hit(REG_ADDR_I, tc_limit_pkg::OFFS_CJ_TEMP_LOWER));

  // release by a cj read; a new result in the same cycle wins
  assign ready_n_d = TC_VALID_I ? 1'b0 : ((rd_cj_byte & cj_sensor_en) ? 1'b1 : ready_n_q);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tc_result_q <= tc_limit_pkg::RST_TC_RESULT;
      ready_n_q <= 1'b1;
    end
    else
    begin
      tc_result_q <= tc_result_d;
      ready_n_q <= ready_n_d;
    end
  end

  assign RESULT_READY_N_O = ready_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // threshold comparison

  logic cj_over;
  logic cj_under;
  logic tc_over;
  logic tc_under;

  limit_compare #(
    .VALUE_W(tc_limit_pkg::CJ_WIDTH),
    .LIMIT_W(tc_limit_pkg::CJ_LIMIT_WIDTH),
    .SHIFT(tc_limit_pkg::CJ_LIMIT_SHIFT)
  ) u_cj_compare (
    .value_i(cj_temp_q),
    .high_limit_i(cj_high_limit_q),
    .low_limit_i(cj_low_limit_q),
    .over_o(cj_over),
    .under_o(cj_under)
  );

  limit_compare #(
    .VALUE_W(tc_limit_pkg::TC_WIDTH),
    .LIMIT_W(tc_limit_pkg::TC_LIMIT_WIDTH),
    .SHIFT(tc_limit_pkg::TC_LIMIT_SHIFT)
  ) u_tc_compare (
    .value_i(tc_result_q),
    .high_limit_i({tc_high_upper_q, tc_high_lower_q}),
    .low_limit_i({tc_low_upper_q, tc_low_lower_q}),
    .over_o(tc_over),
    .under_o(tc_under)
  );

  //////////////////////////////////////////////////////////////////////////////
  // fault flags and fault output

  logic [7:0] fault_cond;
  logic [7:0] fault_flags;

  assign fault_cond[tc_limit_pkg::FLAG_COLD_JUNCTION_OUT_OF_RANGE] = COLD_JUNCTION_OUT_OF_RANGE_I;
  assign fault_cond[tc_limit_pkg::FLAG_THERMOCOUPLE_OUT_OF_RANGE] = THERMOCOUPLE_OUT_OF_RANGE_I;
  assign fault_cond[tc_limit_pkg::FLAG_CJ_HIGH] = cj_over;
  assign fault_cond[tc_limit_pkg::FLAG_CJ_LOW] = cj_under;
  assign fault_cond[tc_limit_pkg::FLAG_TC_HIGH] = tc_over;
  assign fault_cond[tc_limit_pkg::FLAG_TC_LOW] = tc_under;
  assign fault_cond[tc_limit_pkg::FLAG_VOLTAGE] = INPUT_VOLTAGE_FAULT_I;
  assign fault_cond[tc_limit_pkg::FLAG_OPEN] = OPEN_CIRCUIT_I;

  fault_latch u_fault_latch (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .interrupt_mode_i(INTERRUPT_MODE_I),
    .clear_i(FAULT_CLEAR_I),
    .cond_i(fault_cond),
    .flags_o(fault_flags)
  );

  assign fault_n_d = ~|(fault_flags[tc_limit_pkg::MASKABLE_COUNT-1:0] & ~FAULT_MASK_I);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      fault_n_q <= 1'b1;
    else
      fault_n_q <= fault_n_d;
  end

  assign FAULT_N_O = fault_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // read path; unmapped or write-alias reads return zero

  wire logic [6:0] ro = REG_ADDR_I[6:0];
  wire logic rd_ok = ~REG_ADDR_I[tc_limit_pkg::WRITE_FLAG_BIT];

  // lower cj byte low bits read zero
  wire logic [7:0] rd_mux =
    ~rd_ok ? 8'h00 :
    (ro == tc_limit_pkg::OFFS_CJ_HIGH_LIMIT) ? cj_high_limit_q :
    (ro == tc_limit_pkg::OFFS_CJ_LOW_LIMIT) ? cj_low_limit_q :
    (ro == tc_limit_pkg::OFFS_TC_HIGH_UPPER) ? tc_high_upper_q :
    (ro == tc_limit_pkg::OFFS_TC_HIGH_LOWER) ? tc_high_lower_q :
    (ro == tc_limit_pkg::OFFS_TC_LOW_UPPER) ? tc_low_upper_q :
    (ro == tc_limit_pkg::OFFS_TC_LOW_LOWER) ? tc_low_lower_q :
    (ro == tc_limit_pkg::OFFS_CJ_OFFSET) ? cj_offset_q :
    (ro == tc_limit_pkg::OFFS_CJ_TEMP_UPPER) ? cj_temp_q[13:6] :
    (ro == tc_limit_pkg::OFFS_CJ_TEMP_LOWER) ? {cj_temp_q[5:0], 2'h0} :
    (ro == tc_limit_pkg::OFFS_TC_BYTE_TWO) ? tc_result_q[18:11] :
    (ro == tc_limit_pkg::OFFS_TC_BYTE_ONE) ? tc_result_q[10:3] :
    (ro == tc_limit_pkg::OFFS_TC_BYTE_ZERO) ? {tc_result_q[2:0], 5'h00} :
    (ro == tc_limit_pkg::OFFS_FAULT_FLAGS) ? fault_flags :
    8'h00;

  // read data holds until the next read strobe
  assign rdata_d = REG_RD_I ? rd_mux : rdata_q;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      rdata_q <= tc_limit_pkg::RST_READ_DATA;
    else
      rdata_q <= rdata_d;
  end

  assign REG_RDATA_O = rdata_q;

endmodule : tc_fault_limit_regs

/* File: dv/tc_fault_limit_regs_chk.sv */
`timescale 1ns/1ps
module tc_fault_limit_regs_chk (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic INTERRUPT_MODE_I,
  input wire logic FAULT_CLEAR_I,
  input wire logic CJ_SENSOR_DISABLE_I,
  input wire logic [5:0] FAULT_MASK_I,
  input wire logic CJ_VALID_I,
  input wire logic TC_VALID_I,
  input wire logic INPUT_VOLTAGE_FAULT_I,
  input wire logic OPEN_CIRCUIT_I,
  input wire logic [13:0] CJ_TEMP_O,
  input wire logic FAULT_N_O,
  input wire logic RESULT_READY_N_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire cj_read = REG_RD_I && !CJ_SENSOR_DISABLE_I && (REG_ADDR_I == 8'h0a || REG_ADDR_I == 8'h0b);
  wire cj_write = REG_WR_I && (REG_ADDR_I == 8'h8a || REG_ADDR_I == 8'h8b);
  //////////////////////////////////////////////////////////////////////////////
  a_ready_on_result: assert property (TC_VALID_I |=> !RESULT_READY_N_O)
    else $error("ready not low after new result");
  a_ready_release: assert property (cj_read && !TC_VALID_I |=> RESULT_READY_N_O)
    else $error("cj read did not release ready");
  a_ready_hold: assert property (!RESULT_READY_N_O && !cj_read |=> !RESULT_READY_N_O)
    else $error("ready released without cj read");
  a_cj_read_only: assert property (!CJ_SENSOR_DISABLE_I && !CJ_VALID_I |=> $stable(CJ_TEMP_O))
    else $error("cj temp changed without conversion");
  a_cj_kept: assert property (CJ_SENSOR_DISABLE_I && !cj_write |=> $stable(CJ_TEMP_O))
    else $error("cj temp lost while sensor off");
  a_cj_clamp_min: assert property ($signed(CJ_TEMP_O) >= -4096)
    else $error("cj temp below minus 64");
  a_mask_all: assert property ($past(FAULT_MASK_I) == 6'h3f |-> FAULT_N_O)
    else $error("fault pin low with all masked");
  a_open_to_pin: assert property ((OPEN_CIRCUIT_I && !FAULT_MASK_I[0]) [*2] |=> !FAULT_N_O)
    else $error("unmasked open fault missed pin");
  a_comp_release: assert property ((!INTERRUPT_MODE_I && FAULT_MASK_I[5:2] == 4'hf && !INPUT_VOLTAGE_FAULT_I
    && !OPEN_CIRCUIT_I) [*2] |=> FAULT_N_O)
    else $error("fault pin stuck in comparator mode");
  a_latch_hold: assert property (INTERRUPT_MODE_I && $past(INTERRUPT_MODE_I) && !FAULT_CLEAR_I
    && !$past(FAULT_CLEAR_I) && $stable(FAULT_MASK_I) && !FAULT_N_O |=> !FAULT_N_O)
    else $error("latched fault dropped");
  a_bad_read_zero: assert property (REG_RD_I && (REG_ADDR_I[7] || REG_ADDR_I < 8'h03 || REG_ADDR_I > 8'h0f)
    |=> REG_RDATA_O == 8'h00)
    else $error("undefined read not zero");
  c_cj_read: cover property (cj_read);
  c_latched: cover property (INTERRUPT_MODE_I && FAULT_CLEAR_I);
  c_cj_write: cover property (cj_write && CJ_SENSOR_DISABLE_I);
endmodule : tc_fault_limit_regs_chk

bind tc_fault_limit_regs tc_fault_limit_regs_chk tc_fault_limit_regs_chk_inst (.SYS_CLK_I(SYS_CLK_I),
  .RSTN_I(RSTN_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .INTERRUPT_MODE_I(INTERRUPT_MODE_I), .FAULT_CLEAR_I(FAULT_CLEAR_I),
  .CJ_SENSOR_DISABLE_I(CJ_SENSOR_DISABLE_I), .FAULT_MASK_I(FAULT_MASK_I), .CJ_VALID_I(CJ_VALID_I),
  .TC_VALID_I(TC_VALID_I), .INPUT_VOLTAGE_FAULT_I(INPUT_VOLTAGE_FAULT_I), .OPEN_CIRCUIT_I(OPEN_CIRCUIT_I),
  .CJ_TEMP_O(CJ_TEMP_O), .FAULT_N_O(FAULT_N_O), .RESULT_READY_N_O(RESULT_READY_N_O));

/* File: dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  output logic clear_o
);
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
    clear_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // write alias address
  task automatic write_reg(input logic [6:0] offs, input logic [7:0] data);
    @(posedge clk_i);
    addr_o <= {1'b1, offs};
    wdata_o <= data;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // released lines show the inverse so a stale value cannot pass
    wdata_o <= ~data;
    addr_o <= ~{1'b1, offs};
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : read_reg
  task automatic clear_faults();
    @(posedge clk_i);
    clear_o <= 1'b1;
    @(posedge clk_i);
    clear_o <= 1'b0;
  endtask : clear_faults
  task automatic load_cj(input logic [13:0] v);
    write_reg(7'h0a, v[13:6]);
    write_reg(7'h0b, {v[5:0], 2'b00});
  endtask : load_cj
endmodule : host_model

/* File: dv/tc_fault_limit_regs_bench.sv */
`timescale 1ns/1ps
module tc_fault_limit_regs_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, ef, d;
  logic wr, rd, clear, ready_n, fault_n;
  logic int_mode = 1'b0;
  logic dis = 1'b0;
  logic cjv = 1'b0;
  logic tcv = 1'b0;
  logic cjr = 1'b0;
  logic tcr = 1'b0;
  logic vfault = 1'b0;
  logic open = 1'b0;
  logic [5:0] mask = 6'h3f;
  logic [13:0] meas = 14'h0000;
  logic [13:0] cj_temp, ecj;
  logic [18:0] tcres = 19'h00000;
  logic [7:0] regs [3:9];
  logic [7:0] rst_tab [3:15] = '{8'h7f, 8'hc0, 8'h7f, 8'hff, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  int fails = 0;
  int compares = 0;
  int cj, tc;
  always #12.5 clk = ~clk;
  tc_fault_limit_regs tc_fault_limit_regs_inst (.SYS_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .INTERRUPT_MODE_I(int_mode),
    .FAULT_CLEAR_I(clear), .CJ_SENSOR_DISABLE_I(dis), .FAULT_MASK_I(mask), .CJ_MEASURED_I(meas),
    .CJ_VALID_I(cjv), .TC_RESULT_I(tcres), .TC_VALID_I(tcv), .COLD_JUNCTION_OUT_OF_RANGE_I(cjr), .THERMOCOUPLE_OUT_OF_RANGE_I(tcr),
    .INPUT_VOLTAGE_FAULT_I(vfault), .OPEN_CIRCUIT_I(open), .CJ_TEMP_O(cj_temp), .FAULT_N_O(fault_n),
    .RESULT_READY_N_O(ready_n));
  host_model host_model_inst (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd), .clear_o(clear));
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_model_inst.read_reg(a, v);
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, v});
  endtask : rd_chk
  task automatic strobe_valid(input logic c, input logic t);
    @(posedge clk);
    cjv <= c;
    tcv <= t;
    @(posedge clk);
    cjv <= 1'b0;
    tcv <= 1'b0;
  endtask : strobe_valid
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'hdcdcb4f3));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 3; a < 16; a++)
      rd_chk(8'(a), rst_tab[a]);
    host_model_inst.write_reg(7'h0c, 8'hff);
    host_model_inst.write_reg(7'h0f, 8'hff);
    host_model_inst.write_reg(7'h0a, 8'h55);
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h0f, 8'h00);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h83, 8'h00);
    rd_chk(8'h10, 8'h00);
    // comparator mode against random limits, readings and masks
    for (int i = 0; i < 40; i++)
    begin
      for (int r = 3; r < 10; r++)
      begin
        regs[r] = 8'($urandom);
        host_model_inst.write_reg(7'(r), regs[r]);
      end
      @(posedge clk);
      meas <= 14'($urandom);
      tcres <= 19'($urandom);
      mask <= 6'($urandom);
      {cjr, tcr, vfault, open} <= 4'($urandom);
      strobe_valid(1'b1, 1'b1);
      settle(3);
      cj = $signed(meas);
      cj = cj + 4 * $signed(regs[9]);
      cj = (cj > 8191) ? 8191 : (cj < -4096) ? -4096 : cj;
      ecj = 14'(cj);
      tc = $signed(tcres);
      ef = {cjr, tcr, cj > 64 * $signed(regs[3]), cj < 64 * $signed(regs[4]),
        tc > 8 * $signed({regs[5], regs[6]}), tc < 8 * $signed({regs[7], regs[8]}), vfault, open};
      chk("cj temp", 32'(ecj), 32'(cj_temp));
      chk("fault pin", 32'(!(|(ef[5:0] & ~mask))), 32'(fault_n));
      rd_chk(8'h0f, ef);
      rd_chk(8'h0a, ecj[13:6]);
      rd_chk(8'h0b, {ecj[5:0], 2'b00});
      rd_chk(8'h0c, tcres[18:11]);
      rd_chk(8'h0d, tcres[10:3]);
      host_model_inst.read_reg(8'h0e, d);
      chk("tc byte zero", 32'(tcres[2:0]), 32'(d[7:5]));
    end
    // sensor off: cj conversions ignored, tc result still lands, host loads an external reading
    @(posedge clk);
    dis <= 1'b1;
    meas <= 14'h0100;
    strobe_valid(1'b1, 1'b1);
    settle(2);
    chk("ready", 32'h0, 32'(ready_n));
    chk("cj kept", 32'(ecj), 32'(cj_temp));
    host_model_inst.load_cj(14'h0abc);
    settle(1);
    chk("cj loaded", 32'h0abc, 32'(cj_temp));
    rd_chk(8'h0b, 8'hf0);
    chk("ready off", 32'h0, 32'(ready_n));
    host_model_inst.load_cj(14'h2000);
    settle(1);
    chk("cj clamp", 32'h3000, 32'(cj_temp));
    @(posedge clk);
    dis <= 1'b0;
    rd_chk(8'h0a, 8'hc0);
    settle(1);
    chk("ready released", 32'h1, 32'(ready_n));
    // second reset, then interrupt mode latching
    @(posedge clk);
    rstn <= 1'b0;
    {cjr, tcr, vfault, open} <= 4'h0;
    int_mode <= 1'b1;
    mask <= 6'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    open <= 1'b1;
    @(posedge clk);
    open <= 1'b0;
    settle(3);
    chk("latched pin", 32'h0, 32'(fault_n));
    rd_chk(8'h0f, 8'h01);
    host_model_inst.clear_faults();
    settle(2);
    chk("cleared pin", 32'h1, 32'(fault_n));
    rd_chk(8'h0f, 8'h00);
    @(posedge clk);
    open <= 1'b1;
    settle(2);
    host_model_inst.clear_faults();
    rd_chk(8'h0f, 8'h01);
    @(posedge clk);
    mask <= 6'h01;
    cjr <= 1'b1;
    tcr <= 1'b1;
    settle(3);
    chk("masked pin", 32'h1, 32'(fault_n));
    rd_chk(8'h0f, 8'hc1);
    report_and_stop();
  end
endmodule : tc_fault_limit_regs_bench
